// ---- dac_ctrl_map.svh ----
// Register indices, field positions, reset values and counts of the converter mode control.
`ifndef DAC_CTRL_MAP_SVH
`define DAC_CTRL_MAP_SVH
`define IDX_LEFT_GAIN 7'h10
`define IDX_RIGHT_GAIN 7'h11
`define IDX_MUTE_OVR_RESET 7'h12
`define IDX_OUTPUT_DEEMPH 7'h13
`define IDX_FORMAT_ROLLOFF 7'h14
`define IDX_GAIN_RANGE 7'h15
`define POS_SILENCE_LEFT 0
`define POS_SILENCE_RIGHT 1
`define POS_OVERSAMPLE 6
`define POS_SOFT_REINIT 7
`define POS_DISABLE_LEFT 0
`define POS_DISABLE_RIGHT 1
`define POS_DEEMPH_ENABLE 4
`define POS_DEEMPH_RATE_LO 5
`define POS_DEEMPH_RATE_HI 6
`define POS_FORMAT_LO 0
`define POS_FORMAT_HI 2
`define POS_SLOW_ROLLOFF 5
`define POS_RANGE_SEL 0
`define POS_WORD_LEAD 15
`define POS_INDEX_HI 14
`define POS_INDEX_LO 8
`define POS_DATA_HI 7
`define POS_DATA_LO 0
`define GAIN_RESET 8'hff
`define FINE_MUTE_CODE 8'h80
`define WIDE_MUTE_CODE 8'h9a
`define FORMAT_RESET 3'h5
`define DEEMPH_RATE_RESET 2'h0
`define WORD_BITS 5'h10
`define BIT_COUNT_MAX 5'h1f
`define RAMP_LAST_SAMPLE 3'h7
`define REINIT_LAST_CYCLE 11'h3ff
`define OSR_16 8'h10
`define OSR_32 8'h20
`define OSR_64 8'h40
`define MIDSCALE_LEVEL 24'h000000
`endif

// ---- dac_ctrl_pkg.sv ----
// Types shared by the converter mode control modules.
package dac_ctrl_pkg;
  typedef enum logic {CTRL_RUN, CTRL_REINIT} ctrl_state_t;
  typedef enum logic [1:0] {SYSCLK_X128_192, SYSCLK_X256_384, SYSCLK_X512_UP, SYSCLK_SPARE} sysclk_class_t;
  typedef logic [7:0] gain_code_t;
endpackage

// ---- dac_serial_rx.sv ----
// Three-wire write-only control port receiver, sampled on the system clock.
`timescale 1ns/10ps
`include "dac_ctrl_map.svh"
module dac_serial_rx
  import dac_ctrl_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic select_n_in,
  input wire logic shift_clock_in,
  input wire logic serial_in,
  output logic wr_out,
  output logic [6:0] index_out,
  output logic [7:0] data_out
);
  logic [2:0] sync_a;
  logic [2:0] sync_b;
  logic sclk_d;
  logic sel_d;
  logic [15:0] shift;
  logic [4:0] count;

  // Pins: bit 2 select, bit 1 shift clock, bit 0 data; all take the same latency so data keeps its hold.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sync_a <= 3'h7;
      sync_b <= 3'h7;
      sclk_d <= 1'b1;
      sel_d <= 1'b1;
    end else if (ce_in) begin
      sync_a <= {select_n_in, shift_clock_in, serial_in};
      sync_b <= sync_a;
      sclk_d <= sync_b[1];
      sel_d <= sync_b[2];
    end
  end

  wire sel_low = ~sync_b[2];
  wire sclk_rise = sel_low & sync_b[1] & ~sclk_d;
  wire sel_fall = sel_low & sel_d;
  wire sel_rise = sync_b[2] & ~sel_d;
  wire word_ok = (count == `WORD_BITS) & ~shift[`POS_WORD_LEAD];
  wire [4:0] next_count = sel_fall ? 5'h00 : (sclk_rise && count != `BIT_COUNT_MAX) ? count + 5'h01 : count;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      shift <= 16'h0000;
      count <= 5'h00;
    end else if (ce_in) begin
      count <= next_count;
      if (sclk_rise) begin
        shift <= {shift[14:0], sync_b[0]}; // [RQ19]
      end
    end
  end

  // A word is taken only on the select release after exactly sixteen clocks with a zero lead bit.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wr_out <= 1'b0;
      index_out <= 7'h00;
      data_out <= 8'h00;
    end else if (ce_in) begin
      wr_out <= sel_rise & word_ok; // [RQ20]
      if (sel_rise && word_ok) begin
        index_out <= shift[`POS_INDEX_HI:`POS_INDEX_LO]; // [RQ19]
        data_out <= shift[`POS_DATA_HI:`POS_DATA_LO];
      end
    end
  end
endmodule

// ---- dac_gain_ramp.sv ----
// One channel's stepping digital attenuator with soft mute.
`timescale 1ns/10ps
`include "dac_ctrl_map.svh"
module dac_gain_ramp
  import dac_ctrl_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic clear_in,
  input wire logic step_in,
  input wire logic silence_in,
  input wire logic range_in,
  input wire gain_code_t target_in,
  output gain_code_t applied_out,
  output logic [8:0] atten_half_db_out,
  output logic muted_out
);
  wire [7:0] floor_code = range_in ? `WIDE_MUTE_CODE : `FINE_MUTE_CODE; // [RQ3]
  wire goal_muted = silence_in | (target_in <= floor_code); // [RQ3] [RQ7]
  wire [7:0] goal = goal_muted ? floor_code : target_in; // [RQ8]
  // Steps always start from the applied level, so a new goal mid-ramp never jumps.
  wire [7:0] stepped = (step_in && applied_out < goal) ? applied_out + 8'h01 :
                       (step_in && applied_out > goal) ? applied_out - 8'h01 : applied_out; // [RQ4] [RQ21]
  wire [7:0] next_applied = clear_in ? `GAIN_RESET : stepped;
  wire [7:0] next_drop = `GAIN_RESET - next_applied;
  wire [8:0] next_atten = range_in ? {next_drop, 1'b0} : {1'b0, next_drop}; // [RQ1] [RQ2]
  wire next_muted = next_applied <= floor_code; // [RQ3]

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      applied_out <= `GAIN_RESET;
      atten_half_db_out <= 9'h000;
      muted_out <= 1'b0;
    end else if (ce_in) begin
      applied_out <= next_applied; // [RQ7] [RQ8]
      atten_half_db_out <= next_atten;
      muted_out <= next_muted;
    end
  end
endmodule

// ---- dac_mode_ctrl.sv ----
// Mode control top of the stereo converter: serial registers, attenuator ramps, soft reinit, output gating.
// Function
// [RQ1] Attenuation in dB equals step size times gain code minus 255.
// [RQ2] Range clear gives 0.5 dB steps; range set gives 1 dB steps.
// [RQ3] Codes up to 128 fine, or up to 154 wide, mean full mute.
// [RQ4] Applied gain moves one step per eight sample periods toward the target.
// [RQ5] Left and right gain codes are held and written independently.
// [RQ6] Both gain codes reset to all ones, no attenuation.
// [RQ7] Soft mute set ramps that channel down to full mute stepwise.
// [RQ8] Soft mute cleared ramps that channel back up to its programmed level.
// [RQ9] Host writes zero into every reserved bit.
// [RQ10] At 512, 768 or 1152 fs clock, oversampling is x64 or x128.
// [RQ11] At 256 or 384 fs clock, oversampling is x32 or x64.
// [RQ12] At 128 or 192 fs clock, oversampling is x16 or x32.
// [RQ13] Soft reinit acts as power-on reset for 1024 system clocks.
// [RQ14] A disabled channel outputs midscale; an enabled one follows audio.
// [RQ15] De-emphasis is applied only while enabled; it resets disabled.
// [RQ16] Rate field: 00 44.1 kHz, 01 48 kHz, 10 32 kHz, 11 reserved.
// [RQ17] Format field: right-justified 24/20/18/16, I2S, left-justified default.
// [RQ18] Rolloff bit clear selects sharp response, set selects slow.
// [RQ19] Control word: zero, seven index bits, eight data bits, MSB first.
// [RQ20] Select low, sixteen clocks, select high latches the indexed register.
// [RQ21] A target change mid-ramp continues from the applied level.
`timescale 1ns/10ps
`include "dac_ctrl_map.svh"
module dac_mode_ctrl
  import dac_ctrl_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic CE_IN,
  input wire logic CTRL_SELECT_N_IN,
  input wire logic CTRL_SHIFT_CLOCK_IN,
  input wire logic CTRL_SERIAL_IN,
  input wire logic SAMPLE_TICK_IN,
  input wire logic [1:0] SYSCLK_CLASS_IN,
  input wire logic [23:0] LEFT_AUDIO_IN,
  input wire logic [23:0] RIGHT_AUDIO_IN,
  output logic [23:0] LEFT_OUTPUT_OUT,
  output logic [23:0] RIGHT_OUTPUT_OUT,
  output logic [7:0] LEFT_GAIN_APPLIED_OUT,
  output logic [7:0] RIGHT_GAIN_APPLIED_OUT,
  output logic [8:0] LEFT_ATTEN_HALF_DB_OUT,
  output logic [8:0] RIGHT_ATTEN_HALF_DB_OUT,
  output logic LEFT_MUTED_OUT,
  output logic RIGHT_MUTED_OUT,
  output logic ATTEN_RANGE_SEL_OUT,
  output logic [7:0] OVERSAMPLE_RATIO_OUT,
  output logic DEEMPH_ENABLE_OUT,
  output logic [1:0] DEEMPH_RATE_SEL_OUT,
  output logic [2:0] AUDIO_FORMAT_SEL_OUT,
  output logic FILTER_SLOW_ROLLOFF_OUT,
  output logic REINIT_BUSY_OUT
);
  ctrl_state_t state;
  ctrl_state_t next_state;
  logic [10:0] reinit_count;
  logic [2:0] sample_count;
  gain_code_t left_gain_code;
  gain_code_t right_gain_code;
  logic left_silence;
  logic right_silence;
  logic oversample_high;
  logic left_disable;
  logic right_disable;
  logic deemph_enable;
  logic [1:0] deemph_rate_sel;
  logic [2:0] audio_format_sel;
  logic filter_slow_rolloff;
  logic atten_range_sel;
  logic [7:0] oversample_ratio;
  logic rx_wr;
  logic [6:0] rx_index;
  logic [7:0] rx_data;

  dac_serial_rx u_serial_rx (
    .clk_in(CLK_IN),
    .rst_in(RST_IN),
    .ce_in(CE_IN),
    .select_n_in(CTRL_SELECT_N_IN),
    .shift_clock_in(CTRL_SHIFT_CLOCK_IN),
    .serial_in(CTRL_SERIAL_IN),
    .wr_out(rx_wr),
    .index_out(rx_index),
    .data_out(rx_data)
  );

  // Writes are dropped while the soft reinit period runs, as during power-on reset.
  wire busy = (state == CTRL_REINIT);
  wire wr_ok = rx_wr & ~busy;
  wire hit_left = wr_ok & (rx_index == `IDX_LEFT_GAIN);
  wire hit_right = wr_ok & (rx_index == `IDX_RIGHT_GAIN);
  wire hit_mute = wr_ok & (rx_index == `IDX_MUTE_OVR_RESET);
  wire hit_output = wr_ok & (rx_index == `IDX_OUTPUT_DEEMPH);
  wire hit_format = wr_ok & (rx_index == `IDX_FORMAT_ROLLOFF);
  wire hit_range = wr_ok & (rx_index == `IDX_GAIN_RANGE);
  wire start_reinit = hit_mute & rx_data[`POS_SOFT_REINIT]; // [RQ13]
  wire clear_all = RST_IN | (CE_IN & start_reinit); // [RQ13]
  wire reinit_done = (reinit_count == `REINIT_LAST_CYCLE);

  always_comb begin
    next_state = state;
    case (state)
      CTRL_RUN: begin
        if (start_reinit) begin
          next_state = CTRL_REINIT;
        end
      end
      CTRL_REINIT: begin
        if (reinit_done) begin
          next_state = CTRL_RUN;
        end
      end
      default: begin
        next_state = CTRL_RUN;
      end
    endcase
  end

  // The reinit period counts 1024 system clocks from the cycle after the latching write.
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      state <= CTRL_RUN;
      reinit_count <= 11'h000;
    end else if (CE_IN) begin
      state <= next_state;
      reinit_count <= busy ? reinit_count + 11'h001 : 11'h000; // [RQ13]
    end
  end

  // Ramp pacing: one step strobe on every eighth sample tick.
  wire ramp_step = SAMPLE_TICK_IN & (sample_count == `RAMP_LAST_SAMPLE) & ~busy; // [RQ4]

  always_ff @(posedge CLK_IN) begin
    if (clear_all || (CE_IN && busy)) begin
      sample_count <= 3'h0;
    end else if (CE_IN && SAMPLE_TICK_IN) begin
      sample_count <= sample_count + 3'h1; // [RQ4]
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (clear_all) begin
      left_gain_code <= `GAIN_RESET; // [RQ6]
    end else if (CE_IN && hit_left) begin
      left_gain_code <= rx_data; // [RQ5]
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (clear_all) begin
      right_gain_code <= `GAIN_RESET; // [RQ6]
    end else if (CE_IN && hit_right) begin
      right_gain_code <= rx_data; // [RQ5]
    end
  end

  // Reserved bits are expected to be written as zero and are not stored.
  always_ff @(posedge CLK_IN) begin
    if (clear_all) begin
      left_silence <= 1'b0;
      right_silence <= 1'b0;
      oversample_high <= 1'b0;
    end else if (CE_IN && hit_mute) begin
      left_silence <= rx_data[`POS_SILENCE_LEFT]; // [RQ7] [RQ8]
      right_silence <= rx_data[`POS_SILENCE_RIGHT];
      oversample_high <= rx_data[`POS_OVERSAMPLE]; // [RQ9]
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (clear_all) begin
      left_disable <= 1'b0;
      right_disable <= 1'b0;
      deemph_enable <= 1'b0; // [RQ15]
      deemph_rate_sel <= `DEEMPH_RATE_RESET; // [RQ16]
    end else if (CE_IN && hit_output) begin
      left_disable <= rx_data[`POS_DISABLE_LEFT]; // [RQ14]
      right_disable <= rx_data[`POS_DISABLE_RIGHT];
      deemph_enable <= rx_data[`POS_DEEMPH_ENABLE]; // [RQ15]
      deemph_rate_sel <= rx_data[`POS_DEEMPH_RATE_HI:`POS_DEEMPH_RATE_LO]; // [RQ16]
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (clear_all) begin
      audio_format_sel <= `FORMAT_RESET; // [RQ17]
      filter_slow_rolloff <= 1'b0; // [RQ18]
    end else if (CE_IN && hit_format) begin
      audio_format_sel <= rx_data[`POS_FORMAT_HI:`POS_FORMAT_LO]; // [RQ17]
      filter_slow_rolloff <= rx_data[`POS_SLOW_ROLLOFF]; // [RQ18]
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (clear_all) begin
      atten_range_sel <= 1'b0;
    end else if (CE_IN && hit_range) begin
      atten_range_sel <= rx_data[`POS_RANGE_SEL]; // [RQ2]
    end
  end

  // The clock class only picks the base ratio; the oversampling bit doubles it.
  wire [1:0] class_code = SYSCLK_CLASS_IN;
  wire [7:0] base_ratio = (class_code == SYSCLK_X128_192) ? `OSR_16 :
                          (class_code == SYSCLK_X256_384) ? `OSR_32 : `OSR_64; // [RQ10] [RQ11] [RQ12]
  wire [7:0] next_ratio = oversample_high ? {base_ratio[6:0], 1'b0} : base_ratio; // [RQ10] [RQ11] [RQ12]

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      oversample_ratio <= `OSR_32;
    end else if (CE_IN) begin
      oversample_ratio <= next_ratio;
    end
  end

  dac_gain_ramp u_left_ramp (
    .clk_in(CLK_IN),
    .rst_in(RST_IN),
    .ce_in(CE_IN),
    .clear_in(busy | start_reinit),
    .step_in(ramp_step),
    .silence_in(left_silence),
    .range_in(atten_range_sel),
    .target_in(left_gain_code),
    .applied_out(LEFT_GAIN_APPLIED_OUT),
    .atten_half_db_out(LEFT_ATTEN_HALF_DB_OUT),
    .muted_out(LEFT_MUTED_OUT)
  );

  dac_gain_ramp u_right_ramp (
    .clk_in(CLK_IN),
    .rst_in(RST_IN),
    .ce_in(CE_IN),
    .clear_in(busy | start_reinit),
    .step_in(ramp_step),
    .silence_in(right_silence),
    .range_in(atten_range_sel),
    .target_in(right_gain_code),
    .applied_out(RIGHT_GAIN_APPLIED_OUT),
    .atten_half_db_out(RIGHT_ATTEN_HALF_DB_OUT),
    .muted_out(RIGHT_MUTED_OUT)
  );

  // Outputs sit at midscale while disabled or during reinit, so no stale sample leaks out.
  // The latching write already forces midscale, so the first busy cycle shows the reset level too.
  wire quiet_all = busy | start_reinit; // [RQ13]
  wire left_quiet = left_disable | quiet_all;
  wire right_quiet = right_disable | quiet_all;
  wire [23:0] next_left = left_quiet ? `MIDSCALE_LEVEL : LEFT_AUDIO_IN; // [RQ14]
  wire [23:0] next_right = right_quiet ? `MIDSCALE_LEVEL : RIGHT_AUDIO_IN; // [RQ14]

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      LEFT_OUTPUT_OUT <= `MIDSCALE_LEVEL;
      RIGHT_OUTPUT_OUT <= `MIDSCALE_LEVEL;
    end else if (CE_IN && (SAMPLE_TICK_IN || quiet_all)) begin
      LEFT_OUTPUT_OUT <= next_left;
      RIGHT_OUTPUT_OUT <= next_right;
    end
  end

  assign ATTEN_RANGE_SEL_OUT = atten_range_sel;
  assign OVERSAMPLE_RATIO_OUT = oversample_ratio;
  assign DEEMPH_ENABLE_OUT = deemph_enable; // [RQ15]
  assign DEEMPH_RATE_SEL_OUT = deemph_rate_sel;
  assign AUDIO_FORMAT_SEL_OUT = audio_format_sel;
  assign FILTER_SLOW_ROLLOFF_OUT = filter_slow_rolloff;
  assign REINIT_BUSY_OUT = busy;
endmodule

// ---- host_serial_model.sv ----
// Behavioural host that writes control words over the three-wire port.
`timescale 1ns/10ps
module host_serial_model (
  input wire logic clk_in,
  output logic select_n_out,
  output logic shift_clock_out,
  output logic serial_out
);
  initial begin
    select_n_out = 1'b1;
    shift_clock_out = 1'b0;
    serial_out = 1'b0;
  end
  // Each shift clock phase lasts eight system cycles; the clock stands low between frames.
  task automatic send(input logic [15:0] word, input int bits);
    @(posedge clk_in);
    select_n_out <= 1'b0;
    for (int i = 0; i < bits; i++) begin
      serial_out <= word[15 - i];
      repeat (8) @(posedge clk_in);
      shift_clock_out <= 1'b1;
      repeat (8) @(posedge clk_in);
      shift_clock_out <= 1'b0;
    end
    repeat (8) @(posedge clk_in);
    select_n_out <= 1'b1;
    // A released data line is not held, so the last value is not left behind.
    serial_out <= ~serial_out;
    repeat (8) @(posedge clk_in);
  endtask
endmodule

// ---- dac_mode_checker.sv ----
// Concurrent checks on the converter mode control ports.
`timescale 1ns/10ps
module dac_mode_checker (
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic SAMPLE_TICK_IN,
  input wire logic [1:0] SYSCLK_CLASS_IN,
  input wire logic [23:0] LEFT_OUTPUT_OUT,
  input wire logic [7:0] LEFT_GAIN_APPLIED_OUT,
  input wire logic [7:0] RIGHT_GAIN_APPLIED_OUT,
  input wire logic [8:0] LEFT_ATTEN_HALF_DB_OUT,
  input wire logic LEFT_MUTED_OUT,
  input wire logic ATTEN_RANGE_SEL_OUT,
  input wire logic [7:0] OVERSAMPLE_RATIO_OUT,
  input wire logic [2:0] AUDIO_FORMAT_SEL_OUT,
  input wire logic REINIT_BUSY_OUT
);
  logic [10:0] busy_cycles;
  always_ff @(posedge CLK_IN) begin
    if (RST_IN || !REINIT_BUSY_OUT) begin
      busy_cycles <= 11'h000;
    end else begin
      busy_cycles <= busy_cycles + 11'h001;
    end
  end
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);
  // A change to all ones is left out, since reset and reinit load it as well as a ramp step.
  sequence s_left_step;
    $changed(LEFT_GAIN_APPLIED_OUT) && LEFT_GAIN_APPLIED_OUT != 8'hff;
  endsequence
  sequence s_range_held;
    $stable(ATTEN_RANGE_SEL_OUT);
  endsequence
  property p_one_step;
    s_left_step |-> (LEFT_GAIN_APPLIED_OUT - $past(LEFT_GAIN_APPLIED_OUT) == 8'h01) ||
      ($past(LEFT_GAIN_APPLIED_OUT) - LEFT_GAIN_APPLIED_OUT == 8'h01);
  endproperty
  property p_step_on_tick;
    s_left_step |-> $past(SAMPLE_TICK_IN);
  endproperty
  property p_step_gap;
    s_left_step |=> $stable(LEFT_GAIN_APPLIED_OUT) [*7];
  endproperty
  property p_right_tick;
    $changed(RIGHT_GAIN_APPLIED_OUT) && RIGHT_GAIN_APPLIED_OUT != 8'hff |-> $past(SAMPLE_TICK_IN);
  endproperty
  property p_atten;
    s_range_held |-> LEFT_ATTEN_HALF_DB_OUT == (ATTEN_RANGE_SEL_OUT ?
      {8'hff - LEFT_GAIN_APPLIED_OUT, 1'b0} : {1'b0, 8'hff - LEFT_GAIN_APPLIED_OUT});
  endproperty
  property p_muted;
    s_range_held |-> LEFT_MUTED_OUT == (LEFT_GAIN_APPLIED_OUT <= (ATTEN_RANGE_SEL_OUT ? 8'h9a : 8'h80));
  endproperty
  property p_ratio;
    $stable(SYSCLK_CLASS_IN) |-> (SYSCLK_CLASS_IN == 2'h0) ? OVERSAMPLE_RATIO_OUT inside {8'h10, 8'h20} :
      (SYSCLK_CLASS_IN == 2'h1) ? OVERSAMPLE_RATIO_OUT inside {8'h20, 8'h40} : OVERSAMPLE_RATIO_OUT inside {8'h40, 8'h80};
  endproperty
  property p_reinit_len;
    $fell(REINIT_BUSY_OUT) |-> busy_cycles == 11'h400;
  endproperty
  property p_busy_quiet;
    REINIT_BUSY_OUT |-> LEFT_OUTPUT_OUT == 24'h000000 && LEFT_GAIN_APPLIED_OUT == 8'hff && AUDIO_FORMAT_SEL_OUT == 3'h5;
  endproperty
  a_one_step: assert property (p_one_step) else $error("gain moved more than one code");
  a_step_on_tick: assert property (p_step_on_tick) else $error("gain moved without a sample tick");
  a_step_gap: assert property (p_step_gap) else $error("gain steps too close");
  a_right_tick: assert property (p_right_tick) else $error("right gain moved without a tick");
  a_atten: assert property (p_atten) else $error("attenuation figure wrong");
  a_muted: assert property (p_muted) else $error("mute flag wrong");
  a_ratio: assert property (p_ratio) else $error("oversampling ratio outside class");
  a_reinit_len: assert property (p_reinit_len) else $error("reinit period wrong");
  a_busy_quiet: assert property (p_busy_quiet) else $error("state not default during reinit");
endmodule
bind dac_mode_ctrl dac_mode_checker u_checker (.CLK_IN(CLK_IN), .RST_IN(RST_IN), .SAMPLE_TICK_IN(SAMPLE_TICK_IN),
  .SYSCLK_CLASS_IN(SYSCLK_CLASS_IN), .LEFT_OUTPUT_OUT(LEFT_OUTPUT_OUT), .LEFT_GAIN_APPLIED_OUT(LEFT_GAIN_APPLIED_OUT),
  .RIGHT_GAIN_APPLIED_OUT(RIGHT_GAIN_APPLIED_OUT), .LEFT_ATTEN_HALF_DB_OUT(LEFT_ATTEN_HALF_DB_OUT),
  .LEFT_MUTED_OUT(LEFT_MUTED_OUT), .ATTEN_RANGE_SEL_OUT(ATTEN_RANGE_SEL_OUT),
  .OVERSAMPLE_RATIO_OUT(OVERSAMPLE_RATIO_OUT), .AUDIO_FORMAT_SEL_OUT(AUDIO_FORMAT_SEL_OUT),
  .REINIT_BUSY_OUT(REINIT_BUSY_OUT));

// ---- tb_top.sv ----
// Self-checking bench for the converter mode control.
`timescale 1ns/10ps
module tb_top;
  import dac_ctrl_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic tick = 1'b0;
  logic tick_on = 1'b1;
  logic [1:0] tcnt = 2'h0;
  logic [1:0] cls = 2'h1;
  logic [23:0] aud_l = 24'h123456;
  logic [23:0] aud_r = 24'h654321;
  logic sel_n, sclk, sdat, mut_l, mut_r, range, deemph, slow, busy;
  logic [23:0] out_l, out_r;
  gain_code_t app_l, app_r;
  logic [8:0] att_l, att_r;
  logic [7:0] ratio;
  logic [1:0] rate;
  logic [2:0] fmt;
  int mismatches = 0;
  int total_checks = 0;
  always #5 clk = ~clk;
  // One tick every four cycles keeps a ramp step at 32 system cycles.
  always @(posedge clk) begin
    tcnt <= tcnt + 2'h1;
    tick <= tick_on && (tcnt == 2'h3);
  end
  host_serial_model u_host (.clk_in(clk), .select_n_out(sel_n), .shift_clock_out(sclk), .serial_out(sdat));
  dac_mode_ctrl u_dut (.CLK_IN(clk), .RST_IN(rst), .CE_IN(1'b1), .CTRL_SELECT_N_IN(sel_n),
    .CTRL_SHIFT_CLOCK_IN(sclk), .CTRL_SERIAL_IN(sdat), .SAMPLE_TICK_IN(tick), .SYSCLK_CLASS_IN(cls),
    .LEFT_AUDIO_IN(aud_l), .RIGHT_AUDIO_IN(aud_r), .LEFT_OUTPUT_OUT(out_l), .RIGHT_OUTPUT_OUT(out_r),
    .LEFT_GAIN_APPLIED_OUT(app_l), .RIGHT_GAIN_APPLIED_OUT(app_r), .LEFT_ATTEN_HALF_DB_OUT(att_l),
    .RIGHT_ATTEN_HALF_DB_OUT(att_r), .LEFT_MUTED_OUT(mut_l), .RIGHT_MUTED_OUT(mut_r),
    .ATTEN_RANGE_SEL_OUT(range), .OVERSAMPLE_RATIO_OUT(ratio), .DEEMPH_ENABLE_OUT(deemph),
    .DEEMPH_RATE_SEL_OUT(rate), .AUDIO_FORMAT_SEL_OUT(fmt), .FILTER_SLOW_ROLLOFF_OUT(slow),
    .REINIT_BUSY_OUT(busy));
  task automatic check(input logic [23:0] seen, input logic [23:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic wr(input logic [6:0] idx, input logic [7:0] data);
    u_host.send({1'b0, idx, data}, 16);
    @(negedge clk);
  endtask
  task automatic wait_left(input logic [7:0] goal, output int cyc);
    cyc = 0;
    while (app_l !== goal) begin
      @(negedge clk);
      cyc++;
      if (cyc > 20000) begin
        mismatches++;
        $display("wrong value at %0t: ramp never reached %h", $time, goal);
        test_done();
      end
    end
  endtask
  task automatic t_fields();
    for (int r = 0; r < 3; r++) begin
      wr(7'h13, {1'b0, r[1:0], 1'b1, 2'h0, 2'h1});
      check(deemph, 1'b1, "deemph");
      check(rate, r[1:0], "rate");
    end
    check(out_l, 24'h000000, "disabled left");
    check(out_r, aud_r, "right audio");
    wr(7'h13, 8'h00);
    check(deemph, 1'b0, "deemph off");
    check(out_l, aud_l, "left audio");
    for (int f = 0; f < 6; f++) begin
      wr(7'h14, {2'h0, f[0], 2'h0, f[2:0]});
      check(fmt, f[2:0], "format");
      check(slow, f[0], "rolloff");
    end
    $display("test fields done");
  endtask
  task automatic t_ovs();
    logic [7:0] exp [6] = '{8'h10, 8'h20, 8'h20, 8'h40, 8'h40, 8'h80};
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      cls <= i[2:1];
      wr(7'h12, {1'b0, i[0], 6'h00});
      check(ratio, exp[i], "ratio");
    end
    @(posedge clk);
    cls <= 2'h1;
    wr(7'h12, 8'h00);
    $display("test oversampling done");
  endtask
  task automatic t_ramp();
    int c;
    wr(7'h10, 8'hfd);
    wait_left(8'hfe, c);
    wait_left(8'hfd, c);
    check(24'(c), 24'h000020, "step spacing");
    check(att_l, 9'h002, "fine atten");
    check(app_r, 8'hff, "right untouched");
    wr(7'h15, 8'h01);
    check(att_l, 9'h004, "wide atten");
    wr(7'h10, 8'hf8);
    wait_left(8'hfc, c);
    tick_on <= 1'b0;
    wr(7'h10, 8'hfe);
    check(app_l, 8'hfc, "held without ticks");
    tick_on <= 1'b1;
    wait_left(8'hfd, c);
    wait_left(8'hfe, c);
    wr(7'h11, 8'hfe);
    // One ramp step may lie up to eight ticks away after the target lands.
    repeat (32) @(negedge clk);
    check(app_r, 8'hfe, "right gain");
    check(att_r, 9'h002, "right wide atten");
    $display("test ramp done");
  endtask
  task automatic t_mute();
    int c;
    wr(7'h12, 8'h01);
    wait_left(8'h9a, c);
    repeat (64) @(negedge clk);
    check(app_l, 8'h9a, "mute floor");
    check(mut_l, 1'b1, "muted");
    check(att_l, 9'h0ca, "mute atten");
    check(app_r, 8'hfe, "right unmuted");
    check(mut_r, 1'b0, "right mute flag");
    wr(7'h12, 8'h00);
    wait_left(8'hfe, c);
    check(mut_l, 1'b0, "unmuted");
    $display("test mute done");
  endtask
  task automatic t_refuse();
    u_host.send({1'b1, 7'h14, 8'h03}, 16);
    @(negedge clk);
    check(fmt, 3'h5, "lead one dropped");
    u_host.send({1'b0, 7'h14, 8'h03}, 15);
    @(negedge clk);
    check(fmt, 3'h5, "short word dropped");
    wr(7'h14, 8'h03);
    check(fmt, 3'h3, "msb first");
    $display("test refuse done");
  endtask
  task automatic t_reinit();
    // The oversampling bit rides along and must be discarded by the reinit.
    wr(7'h12, 8'hc0);
    check(busy, 1'b1, "busy");
    wr(7'h14, 8'h03);
    check(fmt, 3'h5, "write ignored");
    repeat (1024) @(negedge clk);
    check(busy, 1'b0, "busy ended");
    check(range, 1'b0, "range default");
    check(app_l, 8'hff, "gain default");
    check(ratio, 8'h20, "ratio default");
    $display("test reinit done");
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(negedge clk);
    check(app_l, 8'hff, "left reset");
    check(app_r, 8'hff, "right reset");
    check(fmt, 3'h5, "format reset");
    check(ratio, 8'h20, "ratio reset");
    t_fields();
    t_ovs();
    t_ramp();
    t_mute();
    t_refuse();
    t_reinit();
    test_done();
  end
endmodule
